/* mbu_pkg.sv */
// package: constants and types of the microsequencer branch unit
package mbu_pkg;

   // ************************************************************
   // sizes
   // ************************************************************
   localparam int ADDR_W      = 8;
   localparam int UCODE_WORDS = 256;
   localparam int IN_W        = 8;
   localparam int CNT_W       = 8;
   localparam int STACK_DEPTH = 4;
   localparam int SP_W        = 3;
   localparam int N_COND      = 3;
   localparam int N_TERM      = 4;
   localparam int CID_W       = 4;
   localparam int TID_W       = 2;
   localparam int COND_WORDS  = 64;

   // ************************************************************
   // register byte offsets
   // ************************************************************
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_STATUS   = 8'h04;
   localparam logic [7:0] OFS_TOS      = 8'h08;
   localparam logic [7:0] OFS_UADDR    = 8'h0C;
   localparam logic [7:0] OFS_UDATA_LO = 8'h10;
   localparam logic [7:0] OFS_UDATA_HI = 8'h14;
   localparam logic [7:0] OFS_CADDR    = 8'h18;
   localparam logic [7:0] OFS_CDATA    = 8'h1C;
   localparam logic [7:0] OFS_INPUTS   = 8'h20;

   // ************************************************************
   // field positions and reset values
   // ************************************************************
   localparam int CTRL_RUN_BIT  = 0;
   localparam int ST_PC_LSB     = 0;
   localparam int ST_CNT_LSB    = 8;
   localparam int ST_SEL_LSB    = 16;
   localparam int ST_SP_LSB     = 18;
   localparam int CD_VAL_LSB    = 8;
   localparam int CD_EN_BIT     = 16;
   localparam int UW_HI_W       = 25;
   localparam logic [ADDR_W-1:0] RST_PC  = 8'h00;
   localparam logic [CNT_W-1:0]  RST_CNT = 8'h00;
   localparam logic [1:0]        RST_SEL = 2'h0;

   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [2:0] {
      OP_BRANCH, OP_MASK_PUSH, OP_RETURN, OP_CNT_LOAD, OP_CNT_TEST
   } mbu_op_t;

   typedef struct packed {
      mbu_op_t                           op;
      logic [1:0]                        sel;
      logic [IN_W-1:0]                   imm;
      logic [ADDR_W-1:0]                 dflt;
      logic [N_COND-1:0][ADDR_W-1:0]     tgt;
      logic [N_COND-1:0][CID_W-1:0]      cid;
   } mbu_uword_t;

   typedef struct packed {
      logic            en;
      logic [IN_W-1:0] val;
      logic [IN_W-1:0] care;
   } mbu_term_t;

   typedef struct packed {
      logic        read;
      logic        write;
      logic [7:0]  address;
      logic [31:0] writedata;
   } mbu_avs_req_t;

   typedef struct packed {
      logic [ADDR_W-1:0]                      pc;
      logic [CNT_W-1:0]                       cnt;
      logic [STACK_DEPTH-1:0][ADDR_W-1:0]     stk;
      logic [SP_W-1:0]                        sp;
      logic [1:0]                             sel;
      logic                                   run;
      logic                                   wait_q;
      logic [31:0]                            rdata;
      logic [31:0]                            lo_stage;
      logic [ADDR_W-1:0]                      uaddr;
      logic [CID_W+TID_W-1:0]                 caddr;
   } mbu_state_t;

endpackage : mbu_pkg

/* mbu_branch_unit.sv */
// module: next-address and branch logic of the microsequencer
//
// Operation
// (RL1) four-way branch each clock, chains to sixteen
// (RL2) masked push ANDs inputs with immediate
// (RL3) input seven is msb, input zero lsb
// (RL4) return loads stack top as next address
// (RL5) dispatch: push, then jump, two clocks
// (RL6) pushed value is absolute target address
// (RL7) counter load writes immediate, flag use
// (RL8) counter test picks one of two targets
// (RL9) counter targets may be four-way branches
// (RL10) at most four product terms per condition
// (RL11) conditions checked in fixed priority order
// (RL12) no condition true takes default address
// (RL13) exactly eight branch inputs sampled
// (RL14) select outputs follow current state
// (RL15) select high one, low zero is set two
// (RL16) common signals wired to inputs five-seven
// (RL17) external mux offers three input sets
// (RL18) one input carries state-dependent signals
// (RL19) unconditional step ignores branch inputs
// (RL20) mux choice depends on current state
//
// The Avalon-MM interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module mbu_branch_unit (
   // clock and reset
   input  wire logic                      clk_sys,
   input  wire logic                      rst_n,
   // register bus
   input  wire mbu_pkg::mbu_avs_req_t     avs_req,
   output logic [31:0]                    avs_readdata,
   output logic                           avs_waitrequest,
   // branch inputs and mux selects
   input  wire logic [mbu_pkg::IN_W-1:0]  branch_inputs,
   output logic                           input_set_select_low,
   output logic                           input_set_select_high,
   // current microcode address
   output logic [mbu_pkg::ADDR_W-1:0]     micro_addr
);
   import mbu_pkg::*;

   // ************************************************************
   // memories
   // ************************************************************
   mbu_uword_t ucode    [UCODE_WORDS];
   mbu_term_t  cond_mem [COND_WORDS];

   mbu_state_t                  s_q;
   mbu_state_t                  s_d;
   mbu_uword_t                  uw;
   mbu_uword_t                  uw_next;
   mbu_uword_t                  uw_wdata;
   mbu_term_t                   term_wdata;
   logic                        ucode_we;
   logic                        cond_we;
   logic [N_COND-1:0]           hit;
   logic                        acc;
   logic [7:0]                  ofs;
   logic [ADDR_W-1:0]           tos;
   logic [IN_W-1:0]             masked;

   assign uw     = ucode[s_q.pc];
   assign tos    = (s_q.sp == '0) ? '0 : s_q.stk[0];
   assign masked = branch_inputs & uw.imm;   // RL2 RL3 RL13

   // ************************************************************
   // condition evaluation, sum of up to four product terms
   // ************************************************************
   generate
      for (genvar k = 0; k < N_COND; k++) begin : g_cond
         logic [N_TERM-1:0] th;
         for (genvar j = 0; j < N_TERM; j++) begin : g_term
            mbu_term_t t;
            assign t     = cond_mem[{uw.cid[k], TID_W'(j)}];
            assign th[j] = t.en &
                           (((branch_inputs ^ t.val) & t.care) == '0);
         end
         assign hit[k] = |th;   // RL10
      end
   endgenerate

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      s_d        = s_q;
      ucode_we   = 1'b0;
      cond_we    = 1'b0;
      uw_wdata   = {avs_req.writedata[UW_HI_W-1:0], s_q.lo_stage};
      term_wdata = avs_req.writedata[CD_EN_BIT:0];
      ofs        = avs_req.address;

      // sequencing
      if (s_q.run) begin
         case (uw.op)
            OP_BRANCH: begin
               if (hit[0]) begin                       // RL11
                  s_d.pc = uw.tgt[0];                  // RL1
               end else if (hit[1]) begin              // RL11
                  s_d.pc = uw.tgt[1];
               end else if (hit[2]) begin              // RL11
                  s_d.pc = uw.tgt[2];
               end else begin
                  s_d.pc = uw.dflt;                    // RL12 RL19
               end
            end
            OP_MASK_PUSH: begin
               for (int i = STACK_DEPTH-1; i > 0; i--) begin
                  s_d.stk[i] = s_q.stk[i-1];
               end
               s_d.stk[0] = ADDR_W'(masked);            // RL2 RL5
               if (s_q.sp != SP_W'(STACK_DEPTH)) begin
                  s_d.sp = s_q.sp + SP_W'(1);
               end
               s_d.pc = uw.dflt;
            end
            OP_RETURN: begin
               s_d.pc = tos;                            // RL4 RL5 RL6
               for (int i = 0; i < STACK_DEPTH-1; i++) begin
                  s_d.stk[i] = s_q.stk[i+1];
               end
               s_d.stk[STACK_DEPTH-1] = '0;
               if (s_q.sp != '0) begin
                  s_d.sp = s_q.sp - SP_W'(1);
               end
            end
            OP_CNT_LOAD: begin
               s_d.cnt = hit[0] ? CNT_W'(uw.imm)         // RL7
                                : CNT_W'(uw.tgt[2]);
               s_d.pc  = uw.dflt;
            end
            OP_CNT_TEST: begin
               s_d.pc = (s_q.cnt != '0) ? uw.tgt[1]     // RL8 RL9
                                        : uw.tgt[0];
            end
            default: begin
               s_d.pc = uw.dflt;
            end
         endcase
      end

      // bus slave: one wait cycle, then answer
      acc        = avs_req.read | avs_req.write;
      s_d.wait_q = ~(acc & s_q.wait_q);
      if (acc & s_q.wait_q) begin
         if (avs_req.read) begin
            s_d.rdata = '0;
            case (ofs)
               OFS_CTRL:     s_d.rdata[CTRL_RUN_BIT] = s_q.run;
               OFS_STATUS: begin
                  s_d.rdata[ST_PC_LSB +: ADDR_W] = s_q.pc;
                  s_d.rdata[ST_CNT_LSB +: CNT_W] = s_q.cnt;
                  s_d.rdata[ST_SEL_LSB +: 2]     = s_q.sel;
                  s_d.rdata[ST_SP_LSB +: SP_W]   = s_q.sp;
               end
               OFS_TOS:      s_d.rdata[ADDR_W-1:0] = tos;
               OFS_UADDR:    s_d.rdata[ADDR_W-1:0] = s_q.uaddr;
               OFS_UDATA_LO: s_d.rdata = s_q.lo_stage;
               OFS_CADDR:    s_d.rdata[CID_W+TID_W-1:0] = s_q.caddr;
               OFS_INPUTS:   s_d.rdata[IN_W-1:0] = branch_inputs;
               default:      s_d.rdata = '0;
            endcase
         end
      end
      if (avs_req.write & ~s_q.wait_q) begin
         case (ofs)
            OFS_CTRL:     s_d.run = avs_req.writedata[CTRL_RUN_BIT];
            OFS_UADDR:    s_d.uaddr = avs_req.writedata[ADDR_W-1:0];
            OFS_UDATA_LO: s_d.lo_stage = avs_req.writedata;
            OFS_UDATA_HI: ucode_we = 1'b1;
            OFS_CADDR:
               s_d.caddr = avs_req.writedata[CID_W+TID_W-1:0];
            OFS_CDATA:    cond_we = 1'b1;
            default:      ucode_we = 1'b0;
         endcase
      end

      // selects of the word about to execute, held while stopped
      uw_next = ucode[s_d.pc];
      if (s_d.run) begin
         s_d.sel = uw_next.sel;                        // RL14 RL20
      end
   end

   // ************************************************************
   // memory writes
   // ************************************************************
   always_ff @(posedge clk_sys) begin
      if (ucode_we) begin
         ucode[s_q.uaddr] <= uw_wdata;
      end
      if (cond_we) begin
         cond_mem[s_q.caddr] <= term_wdata;
      end
   end

   // ************************************************************
   // state register
   // ************************************************************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_q        <= '0;
         s_q.pc     <= RST_PC;
         s_q.cnt    <= RST_CNT;
         s_q.sel    <= RST_SEL;
         s_q.wait_q <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign avs_readdata          = s_q.rdata;
   assign avs_waitrequest       = s_q.wait_q;
   assign input_set_select_low  = s_q.sel[0];   // RL15
   assign input_set_select_high = s_q.sel[1];   // RL15 RL18
   assign micro_addr            = s_q.pc;

endmodule : mbu_branch_unit

`default_nettype wire

/* mbu_input_mux.sv */
// partner model: state-driven input multiplexer
`timescale 1ns/10ps
`default_nettype none
module mbu_input_mux (
   // selects from the sequencer
   input  wire logic                     input_set_select_low,
   input  wire logic                     input_set_select_high,
   // system signals, bit 0 = a up to bit 11 = l
   input  wire logic [11:0]              sys_sig,
   // routed branch inputs
   output logic [mbu_pkg::IN_W-1:0]      branch_inputs
);
   import mbu_pkg::*;
   logic [4:0] low;
   // ************
   // routing
   // ************
   always_comb begin
      case ({input_set_select_high, input_set_select_low})
         2'h1:    low = sys_sig[6:2];
         2'h2:    low = {sys_sig[8], sys_sig[9], sys_sig[10], sys_sig[11], 1'b0};
         2'h3:    low = {sys_sig[8], sys_sig[9], 1'b0, sys_sig[3], sys_sig[2]};
         default: low = 5'h00;
      endcase
   end
   assign branch_inputs = {sys_sig[0], sys_sig[1], sys_sig[7], low};
endmodule : mbu_input_mux
`default_nettype wire

/* mbu_chk.sv */
// checker: port relations of the branch unit
`timescale 1ns/10ps
`default_nettype none
module mbu_chk (
   // clock and reset
   input wire logic                      clk_sys,
   input wire logic                      rst_n,
   // register bus
   input wire mbu_pkg::mbu_avs_req_t     avs_req,
   input wire logic [31:0]               avs_readdata,
   input wire logic                      avs_waitrequest,
   // branch side
   input wire logic [mbu_pkg::IN_W-1:0]  branch_inputs,
   input wire logic                      input_set_select_low,
   input wire logic                      input_set_select_high,
   input wire logic [mbu_pkg::ADDR_W-1:0] micro_addr
);
   import mbu_pkg::*;
   logic       req;
   logic       ans;
   logic [1:0] sel;
   assign req = avs_req.read | avs_req.write;
   assign ans = avs_req.read & ~avs_waitrequest;
   assign sel = {input_set_select_high, input_set_select_low};
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // ************
   // assertions
   // ************
   bus_answer_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus request not answered");
   wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("wait low too long");
   wait_cause_a: assert property (!avs_waitrequest |-> $past(req))
      else $error("answer without request");
   unmapped_zero_a: assert property (ans && (avs_req.address[1:0] != 2'h0
      || avs_req.address > OFS_INPUTS) |-> avs_readdata == '0)
      else $error("unmapped read not zero");
   rdata_hold_a: assert property ($changed(avs_readdata) |-> ans)
      else $error("read data moved");
   commit_zero_a: assert property (ans && (avs_req.address == OFS_UDATA_HI
      || avs_req.address == OFS_CDATA) |-> avs_readdata == '0)
      else $error("commit read not zero");
   inputs_read_a: assert property (ans && avs_req.address == OFS_INPUTS
      |-> avs_readdata == {24'h00_0000, $past(branch_inputs)})
      else $error("input read wrong");
   status_read_a: assert property (ans && avs_req.address == OFS_STATUS
      |-> avs_readdata[7:0] == $past(micro_addr)
      && avs_readdata[17:16] == $past(sel))
      else $error("status read wrong");
   cover property (ans && avs_req.address == OFS_INPUTS);
   cover property (sel == 2'h2);
   cover property (micro_addr == 8'h1E);
endmodule : mbu_chk
`default_nettype wire

/* test_microsequencer_branch_unit.sv */
// testbench: branch unit against the mux model
`timescale 1ns/10ps
`default_nettype none
module test_microsequencer_branch_unit;
   import mbu_pkg::*;
   logic         clk_sys, rst_n, lo, hi, wreq;
   mbu_avs_req_t req;
   logic [31:0]  rdat, q;
   logic [7:0]   bin, pc;
   logic [11:0]  sys;
   int           failures, samples_checked, cyc, n, k;
   // steps, counter, final address, system signals
   logic [31:0]  tc [10] = '{32'h0301_4109, 32'h0301_4809, 32'h0301_508B,
      32'h0301_600A, 32'h0301_7008, 32'h0511_E094, 32'h0511_F014,
      32'h0400_7010, 32'h0200_E038, 32'h0200_8064};
   logic [7:0]   halts [11] = '{8'h07, 8'h08, 8'h0A, 8'h0C, 8'h0E, 8'h14,
      8'h15, 8'h16, 8'h17, 8'h1E, 8'h1F};
   mbu_branch_unit uut (.clk_sys(clk_sys), .rst_n(rst_n), .avs_req(req),
      .avs_readdata(rdat), .avs_waitrequest(wreq), .branch_inputs(bin),
      .input_set_select_low(lo), .input_set_select_high(hi), .micro_addr(pc));
   mbu_input_mux mux (.input_set_select_low(lo), .input_set_select_high(hi),
      .sys_sig(sys), .branch_inputs(bin));
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 8000) begin
         failures++;
         results();
      end
   end
   task automatic check(input logic [31:0] s, e, input string m);
      samples_checked++;
      if (s !== e) begin
         failures++;
         $display("wrong value at %0t: %s %h not %h", $time, m, s, e);
      end
   endtask : check
   task automatic bus(input logic r, input logic [7:0] a, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge clk_sys);
      req <= '{r, !r, a, d};
      do begin
         @(posedge clk_sys);
         t++;
      end while (wreq !== 1'b0 && t < 50);
      if (wreq !== 1'b0) failures++;
      q = rdat;
      req <= '0;
   endtask : bus
   task automatic rd(input logic [7:0] a, input logic [31:0] e, string m);
      bus(1'b1, a, '0);
      check(q, e, m);
   endtask : rd
   task automatic put(input logic [7:0] a, input mbu_uword_t w);
      bus(1'b0, OFS_UADDR, {24'h00_0000, a});
      bus(1'b0, OFS_UDATA_LO, w[31:0]);
      bus(1'b0, OFS_UDATA_HI, {7'h00, w[56:32]});
   endtask : put
   task automatic term(input logic [3:0] c, input logic [1:0] t, logic [7:0] v);
      bus(1'b0, OFS_CADDR, {26'h000_0000, c, t});
      bus(1'b0, OFS_CDATA, {15'h0000, |v, v, v});
   endtask : term
   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : results
   initial begin
      failures = 0;
      samples_checked = 0;
      cyc = 0;
      rst_n = 1'b0;
      req = '0;
      sys = '0;
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd(OFS_STATUS, '0, "status reset");
      rd(OFS_CTRL, '0, "ctrl reset");
      rd(8'h24, '0, "unmapped");
      rd(8'h06, '0, "misaligned");
      for (k = 0; k < 24; k++) term(k[5:2], k[1:0], 8'h00);
      for (k = 0; k < 4; k++) term(4'h1, k[1:0], 8'h80 | (8'h02 << k));
      term(4'h2, 2'h0, 8'h20);
      term(4'h3, 2'h0, 8'h40);
      term(4'h4, 2'h0, 8'h01);
      term(4'h5, 2'h0, 8'h20);
      put(8'h00, '{OP_MASK_PUSH, 2'h1, 8'h0E, 8'h01, '0, '0});
      put(8'h01, '{OP_RETURN, 2'h0, 8'h00, 8'h00, '0, '0});
      put(8'h02, '{OP_BRANCH, 2'h2, 8'h00, 8'h17, 24'h16_1514, 12'h321});
      put(8'h04, '{OP_CNT_LOAD, 2'h1, 8'h01, 8'h05, '0, 12'h004});
      put(8'h05, '{OP_CNT_TEST, 2'h1, 8'h00, 8'h00, 24'h00_0607, '0});
      put(8'h06, '{OP_BRANCH, 2'h3, 8'h00, 8'h1F, 24'h00_001E, 12'h005});
      foreach (halts[i]) put(halts[i], '{OP_BRANCH, 2'h0, 8'h00, halts[i], '0, '0});
      rd(OFS_UDATA_HI, '0, "commit");
      $display("test registers done");
      for (k = 0; k < 10; k++) begin
         @(posedge clk_sys);
         rst_n <= 1'b0;
         sys <= tc[k][11:0];
         @(posedge clk_sys);
         rst_n <= 1'b1;
         bus(1'b0, OFS_CTRL, 32'h0000_0001);
         n = 0;
         while (pc !== tc[k][19:12] && n < 20) begin
            @(negedge clk_sys);
            if (pc !== 8'h00) n++;
         end
         check(n, tc[k][27:24], "steps");
         check(pc, tc[k][19:12], "target");
         rd(OFS_STATUS, {16'h0000, tc[k][23:12]}, "status");
         rd(OFS_TOS, '0, "stack");
         rd(OFS_INPUTS, {24'h00_0000, sys[0], sys[1], sys[7], 5'h00}, "in");
         $display("test case %0d done", k);
      end
      results();
   end
endmodule : test_microsequencer_branch_unit
bind mbu_branch_unit mbu_chk chk (.clk_sys(clk_sys), .rst_n(rst_n),
   .avs_req(avs_req), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .branch_inputs(branch_inputs),
   .input_set_select_low(input_set_select_low),
   .input_set_select_high(input_set_select_high), .micro_addr(micro_addr));
`default_nettype wire
